/* bench/sbr_ctrl_sva.sv */
/* Port checker of sbr_ctrl.
   Assumes sbr_consts.svh on include path. */
`include "sbr_consts.svh"

module sbr_ctrl_sva (
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // register port
    input wire sbr_pkg::sbr_addr_t reg_addr,
    input wire sbr_pkg::sbr_word_t reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire sbr_pkg::sbr_word_t reg_rdata,
    // trips, bank and reset pulses
    input wire logic [3:0] trip_route,
    input wire logic [3:0] trip_output,
    input wire logic active_bank,
    input wire logic setting_lamp_on,
    input wire logic clear_indicators,
    input wire logic unlatch_outputs,
    input wire logic erase_registers
);
    timeunit 1ns;
    timeprecision 100ps;
    import sbr_pkg::*;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);
    logic rst_wr;
    assign rst_wr = reg_wr && reg_addr == `SBR_OFF_RESET;
    ////////////////////////////////////////
    AST_BUS_UNL: assert property (rst_wr && reg_wdata[0] |=> clear_indicators && unlatch_outputs)
        else $error("unlatch command gave no pulses");
    AST_BUS_ALL: assert property (rst_wr && reg_wdata[1] |=> erase_registers && unlatch_outputs)
        else $error("reset-all command gave no erase");
    AST_ERASE_SCOPE: assert property (erase_registers |-> unlatch_outputs && clear_indicators)
        else $error("erase without narrower scopes");
    AST_UNL_SCOPE: assert property (unlatch_outputs |-> clear_indicators)
        else $error("unlatch without indicator clear");
    AST_ONE_PULSE: assert property (clear_indicators |=> !clear_indicators)
        else $error("clear pulse longer than one cycle");
    AST_TRIP_PASS: assert property (|trip_route |=> (trip_output & $past(trip_route)) == $past(trip_route))
        else $error("routed trip missing at output");
    AST_LAMP_MAIN: assert property (!active_bank [*3] |-> setting_lamp_on)
        else $error("lamp not steady on main bank");
    AST_RD_IDLE: assert property (!reg_rd |=> reg_rdata == 32'h0)
        else $error("read data outside the answer cycle");
    COV_ERASE: cover property (erase_registers);
    COV_FLASH: cover property (active_bank && !setting_lamp_on);
    COV_HOLD: cover property (trip_output[0] && !trip_route[0]);
endmodule // sbr_ctrl_sva

bind sbr_ctrl sbr_ctrl_sva u_sva (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .trip_route(trip_route), .trip_output(trip_output),
    .active_bank(active_bank), .setting_lamp_on(setting_lamp_on), .clear_indicators(clear_indicators),
    .unlatch_outputs(unlatch_outputs), .erase_registers(erase_registers));

/* bench/sbr_stage_model.sv */
/* Stage model: registered start, trip and route levels.
   Assumes one pattern per clock. */
module sbr_stage_model (
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // pattern: route, ef trip, ef start, oc trip, oc start
    input wire logic [13:0] stim,
    // stage levels
    output logic [2:0] oc_start,
    output logic [2:0] oc_trip,
    output logic [1:0] ef_start,
    output logic [1:0] ef_trip,
    output logic [3:0] trip_route
);
    timeunit 1ns;
    timeprecision 100ps;
    // idle in reset
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            {trip_route, ef_trip, ef_start, oc_trip, oc_start} <= 14'h0;
        end else begin
            {trip_route, ef_trip, ef_start, oc_trip, oc_start} <= stim;
        end
    end
endmodule // sbr_stage_model

/* bench/tb_top.sv */
/* Bench of sbr_ctrl with the stage model.
   Assumes rtl compiled first, sbr_consts.svh on include path. */
`include "sbr_consts.svh"

module tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    import sbr_pkg::*;
    localparam logic [2:0] PB [4] = '{3'h4, 3'h3, 3'h2, 3'h6};
    localparam logic [2:0] PE [4] = '{3'h1, 3'h3, 3'h0, 3'h7};
    logic clk = 1'b0, sys_rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, irq, ar_c, ar_p, ar_g;
    sbr_addr_t reg_addr = 8'h00;
    sbr_word_t reg_wdata = 32'h0, reg_rdata;
    logic [2:0] oc_start, oc_trip, ar_exp;
    logic [1:0] ef_start, ef_trip;
    logic [3:0] trip_route, trip_output;
    logic active_bank, lamp, lamp_p, clr, unl, ers, rd_q = 1'b0, ar_on = 1'b0, ar_on_q = 1'b0;
    logic ext_a = 1'b0, ext_b = 1'b0, btn_r = 1'b0, btn_p = 1'b0, dark = 1'b0;
    logic bank_wr = 1'b0, bank_val = 1'b0, set_wr = 1'b0;
    sbr_idx_t set_idx = 3'h0;
    sbr_set_t set_wd = 16'h0, set_rd, r1, r2;
    logic [13:0] stim = 14'h0;
    logic [9:0] m_c = 10'h000, sig;
    logic [5:0] m_p = 6'h00;
    logic [3:0] m_g = 4'h0;
    logic [31:0] rq[$];
    logic [2:0] pq[$];
    int err_count = 0, n_tests = 0, n;
    assign sig = {ef_trip, ef_start, oc_trip, oc_start};
    always #12.5 clk = ~clk;

    sbr_stage_model u_stage (.clk(clk), .sys_rst(sys_rst), .stim(stim), .oc_start(oc_start),
        .oc_trip(oc_trip), .ef_start(ef_start), .ef_trip(ef_trip), .trip_route(trip_route));
    // short flash period keeps the lamp check brief
    sbr_ctrl #(.FLASH_HALF_CYC(4)) uut (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq),
        .oc_start(oc_start), .oc_trip(oc_trip), .ef_start(ef_start), .ef_trip(ef_trip),
        .trip_route(trip_route), .reclose_init_combined(ar_c), .reclose_init_phase(ar_p),
        .reclose_init_ground(ar_g), .trip_output(trip_output), .ext_control_in_a(ext_a),
        .ext_control_in_b(ext_b), .ext_control_in_c(ext_b), .panel_reset_btn(btn_r),
        .panel_program_btn(btn_p), .display_dark(dark), .panel_bank_wr(bank_wr), .panel_bank_val(bank_val),
        .panel_set_idx(set_idx), .panel_set_wr(set_wr), .panel_set_wdata(set_wd), .panel_set_rdata(set_rd),
        .active_bank(active_bank), .setting_lamp_on(lamp), .clear_indicators(clr),
        .unlatch_outputs(unl), .erase_registers(ers));
    ////////////////////////////////////////
    task automatic chk(input sbr_word_t e, g);
        n_tests++;
        if (g !== e) begin
            err_count++;
            $display("BAD t=%0t exp=%h got=%h", $time, e, g);
        end
    endtask
    task automatic stop_test();
        $display("checks %0d, mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic wt(input int c);
        repeat (c) @(posedge clk);
    endtask
    task automatic wr(input sbr_addr_t a, input sbr_word_t d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        wt(1);
        reg_wr <= 1'b0;
        wt(1);
    endtask
    task automatic rd(input sbr_addr_t a, input sbr_word_t e);
        rq.push_back(e);
        reg_addr <= a;
        reg_rd <= 1'b1;
        wt(1);
        reg_rd <= 1'b0;
        wt(1);
    endtask
    task automatic wait_bank(input logic v);
        int k;
        for (k = 0; active_bank !== v && k < 20; k++) wt(1);
        chk({31'h0, v}, {31'h0, active_bank});
        if (k == 20) stop_test();
    endtask
    ////////////////////////////////////////
    // notes matched oldest first
    always @(posedge clk) begin
        if (rd_q) chk(rq.size() ? rq.pop_front() : 32'hFFFFFFFF, reg_rdata);
        if ((clr | unl | ers) === 1'b1)
            chk(pq.size() ? {29'h0, pq.pop_front()} : 32'hFFFF, {29'h0, ers, unl, clr});
        if (ar_on_q) chk({29'h0, ar_exp}, {29'h0, ar_c, ar_p, ar_g});
        rd_q <= reg_rd;
        ar_on_q <= ar_on;
        ar_exp <= {|(m_c & sig), |(m_p & sig[5:0]), |(m_g & sig[9:6])};
    end
    initial begin
        wt(20000);
        err_count++;
        stop_test();
    end
    initial begin
        void'($urandom(32'ha0d7));
        wt(8);
        sys_rst <= 1'b0;
        wt(1);
        rd(`SBR_OFF_BANK, 32'h0);
        rd(`SBR_OFF_IRQ_STAT, 32'h0);
        rd(8'h80, 32'h0);
        $display("defaults done");
        for (int i = 0; i < 2; i++) begin
            ar_on <= 1'b0;
            wt(1);
            m_c = i ? 10'($urandom) : 10'h3FF;
            m_p = i ? 6'($urandom) : 6'h00;
            m_g = 4'($urandom);
            wr(`SBR_OFF_AR_CMB, {22'h0, m_c});
            wr(`SBR_OFF_AR_PH, {26'h0, m_p});
            wr(`SBR_OFF_AR_GND, {28'h0, m_g});
            ar_on <= 1'b1;
            repeat (30) begin
                stim <= {4'h0, 10'($urandom)};
                wt(1);
            end
        end
        stim <= 14'h0;
        ar_on <= 1'b0;
        $display("reclose done");
        wr(`SBR_OFF_IRQ_MASK, 32'hE);
        pq.push_back(3'h3);
        wr(`SBR_OFF_RESET, 32'h1);
        wt(1);
        chk(32'h1, {31'h0, irq});
        pq.push_back(3'h7);
        wr(`SBR_OFF_RESET, 32'h2);
        rd(`SBR_OFF_IRQ_STAT, 32'hE);
        wr(`SBR_OFF_IRQ_STAT, 32'hF);
        wr(`SBR_OFF_IRQ_MASK, 32'h0);
        pq.push_back(3'h3);
        wr(`SBR_OFF_RESET, 32'h1);
        wt(1);
        chk(32'h0, {31'h0, irq});
        rd(`SBR_OFF_IRQ_STAT, 32'h6);
        wr(`SBR_OFF_IRQ_STAT, 32'hF);
        $display("bus reset done");
        wr(`SBR_OFF_HOLD, 32'h1);
        stim <= 14'h0C00;
        wt(3);
        stim <= 14'h0;
        wt(3);
        chk(32'h1, {28'h0, trip_output});
        pq.push_back(3'h3);
        wr(`SBR_OFF_RESET, 32'h1);
        wt(1);
        chk(32'h0, {28'h0, trip_output});
        $display("self-hold done");
        r1 = 16'($urandom);
        r2 = 16'($urandom);
        wr(`SBR_OFF_BANK0 + 8'h08, {16'h0, r1});
        wr(`SBR_OFF_BANK1 + 8'h08, {16'h0, r2});
        set_idx <= 3'h2;
        wt(2);
        chk({16'h0, r1}, {16'h0, set_rd});
        wr(`SBR_OFF_BANK, 32'h1);
        wt(2);
        chk({16'h0, r2}, {16'h0, set_rd});
        rd(`SBR_OFF_BANK, 32'h5);
        rd(`SBR_OFF_BANK0 + 8'h08, {16'h0, r1});
        n = 0;
        repeat (20) begin
            lamp_p = lamp;
            wt(1);
            if (lamp !== lamp_p) n++;
        end
        chk(32'h1, {31'h0, n >= 4});
        bank_val <= 1'b0;
        bank_wr <= 1'b1;
        wt(1);
        bank_wr <= 1'b0;
        wt(3);
        chk(32'h0, {31'h0, active_bank});
        chk(32'h1, {31'h0, lamp});
        set_idx <= 3'h3;
        set_wd <= r2;
        set_wr <= 1'b1;
        wt(1);
        set_wr <= 1'b0;
        rd(`SBR_OFF_BANK0 + 8'h0C, {16'h0, r2});
        rd(`SBR_OFF_BANK1 + 8'h0C, 32'h0);
        $display("bank done");
        wr(`SBR_OFF_EXT_A, 32'h20);
        wr(`SBR_OFF_BANK, 32'h1);
        wt(3);
        chk(32'h0, {31'h0, active_bank});
        ext_a <= 1'b1;
        wait_bank(1'b1);
        ext_a <= 1'b0;
        wait_bank(1'b0);
        wr(`SBR_OFF_EXT_A, 32'h0);
        wt(2);
        chk(32'h0, {31'h0, active_bank});
        for (int i = 0; i < 3; i++) begin
            wr(i == 2 ? `SBR_OFF_EXT_C : `SBR_OFF_EXT_B, 32'h40 << i);
            pq.push_back(3'((2 << i) - 1));
            ext_b <= 1'b1;
            wt(10);
            ext_b <= 1'b0;
            wt(6);
        end
        wr(`SBR_OFF_EXT_B, 32'h0);
        $display("external input done");
        for (int i = 0; i < 4; i++) begin
            {btn_r, btn_p, dark} <= PB[i];
            if (PE[i] != 3'h0) pq.push_back(PE[i]);
            wt(6);
            {btn_r, btn_p} <= 2'h0;
            wt(8);
        end
        $display("panel reset done");
        chk(32'h0, 32'(pq.size()));
        stop_test();
    end
endmodule // tb_top

/* rtl/sbr_bank_store.sv */
/*
 * Main and second setting banks held in flip-flops.
 * Assumes the bus side may reach either bank and the panel only the active one.
 */
`include "sbr_consts.svh"

module sbr_bank_store (
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // bank in use
    input wire logic active_bank,
    // bus side
    input wire logic bus_bank,
    input wire sbr_pkg::sbr_idx_t bus_idx,
    input wire logic bus_wr,
    input wire sbr_pkg::sbr_set_t bus_wdata,
    output sbr_pkg::sbr_set_t bus_rdata,
    // panel side
    input wire sbr_pkg::sbr_idx_t pnl_idx,
    input wire logic pnl_wr,
    input wire sbr_pkg::sbr_set_t pnl_wdata,
    output sbr_pkg::sbr_set_t pnl_rdata
);
    import sbr_pkg::*;

    sbr_set_t mem_q [2][`SBR_SET_WORDS];

    // bus write wins when both hit the same word
    for (genvar b = 0; b < 2; b++) begin : g_bank
        for (genvar i = 0; i < `SBR_SET_WORDS; i++) begin : g_word
            always_ff @(posedge clk) begin
                if (sys_rst) begin
                    mem_q[b][i] <= `SBR_RST_SET;
                end else if (bus_wr && bus_bank == 1'(b) && bus_idx == 3'(i)) begin
                    mem_q[b][i] <= bus_wdata;
                end else if (pnl_wr && active_bank == 1'(b) && pnl_idx == 3'(i)) begin
                    mem_q[b][i] <= pnl_wdata;
                end
            end
        end
    end

    assign bus_rdata = mem_q[bus_bank][bus_idx];
    assign pnl_rdata = mem_q[active_bank][pnl_idx];
endmodule // sbr_bank_store

/* rtl/sbr_consts.svh */
/*
 * Register offsets, field positions, reset values and timing figures of the
 * setting bank and reset logic.
 * Assumes byte addressing with one aligned 32-bit word per register.
 */
`ifndef SBR_CONSTS_SVH
`define SBR_CONSTS_SVH

// register offsets
`define SBR_OFF_BANK 8'h00
`define SBR_OFF_RESET 8'h04
`define SBR_OFF_AR_CMB 8'h08
`define SBR_OFF_AR_PH 8'h0C
`define SBR_OFF_AR_GND 8'h10
`define SBR_OFF_EXT_A 8'h14
`define SBR_OFF_EXT_B 8'h18
`define SBR_OFF_EXT_C 8'h1C
`define SBR_OFF_HOLD 8'h20
`define SBR_OFF_IRQ_STAT 8'h24
`define SBR_OFF_IRQ_MASK 8'h28
`define SBR_OFF_BANK0 8'h40
`define SBR_OFF_BANK1 8'h60

// setting store window: addr[7:6] selects it, addr[5] the bank, addr[4:2] the word
`define SBR_WIN_SEL 2'h1
`define SBR_SET_WORDS 8

// bank register fields
`define SBR_BANK_SEL_BIT 0
`define SBR_BANK_LOCK_BIT 1
`define SBR_BANK_SOFT_BIT 2
`define SBR_BANK_MAIN 1'h0
`define SBR_BANK_SECOND 1'h1

// reset command fields
`define SBR_RST_UNLATCH_BIT 0
`define SBR_RST_ALL_BIT 1

// external input switchgroup fields
`define SBR_EXT_BANK_BIT 5
`define SBR_EXT_IND_BIT 6
`define SBR_EXT_UNL_BIT 7
`define SBR_EXT_ERASE_BIT 8
`define SBR_EXT_W 9

// initiation mask widths
`define SBR_CMB_W 10
`define SBR_PH_W 6
`define SBR_GND_W 4

// interrupt status fields
`define SBR_IRQ_BANK 0
`define SBR_IRQ_IND 1
`define SBR_IRQ_UNL 2
`define SBR_IRQ_ERASE 3
`define SBR_IRQ_W 4

// reset values
`define SBR_RST_CMB 10'h000
`define SBR_RST_PH 6'h00
`define SBR_RST_GND 4'h0
`define SBR_RST_EXT 9'h000
`define SBR_RST_HOLD 4'h0
`define SBR_RST_SET 16'h0000

// lamp flash half period
`define SBR_FLASH_HALF_MS 250
`define SBR_CLK_KHZ 40000

`endif

/* rtl/sbr_ctrl.sv */
/*
 * Reclose initiation, setting bank selection and reset scopes of a feeder
 * protection module, with a plain register port and a level interrupt.
 * Assumes protection stage signals and panel strobes come from logic on clk;
 * external control inputs and panel buttons are pins and get synchronised.
 */
`include "sbr_consts.svh"

module sbr_ctrl #(
    parameter int unsigned FLASH_HALF_CYC = `SBR_FLASH_HALF_MS * `SBR_CLK_KHZ
) (
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // register port
    input wire sbr_pkg::sbr_addr_t reg_addr,
    input wire sbr_pkg::sbr_word_t reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output sbr_pkg::sbr_word_t reg_rdata,
    output logic irq,
    // protection stage signals
    input wire logic [2:0] oc_start,
    input wire logic [2:0] oc_trip,
    input wire logic [1:0] ef_start,
    input wire logic [1:0] ef_trip,
    input wire logic [3:0] trip_route,
    // reclose initiation and trip outputs
    output logic reclose_init_combined,
    output logic reclose_init_phase,
    output logic reclose_init_ground,
    output logic [3:0] trip_output,
    // external control pins
    input wire logic ext_control_in_a,
    input wire logic ext_control_in_b,
    input wire logic ext_control_in_c,
    // panel buttons and menu
    input wire logic panel_reset_btn,
    input wire logic panel_program_btn,
    input wire logic display_dark,
    input wire logic panel_bank_wr,
    input wire logic panel_bank_val,
    input wire sbr_pkg::sbr_idx_t panel_set_idx,
    input wire logic panel_set_wr,
    input wire sbr_pkg::sbr_set_t panel_set_wdata,
    output sbr_pkg::sbr_set_t panel_set_rdata,
    // bank and reset status
    output logic active_bank,
    output logic setting_lamp_on,
    output logic clear_indicators,
    output logic unlatch_outputs,
    output logic erase_registers
);
    import sbr_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // pin synchronisation

    logic [4:0] pins_s;
    logic [2:0] ext_s;
    logic [2:0] ext_prev_q;
    logic rst_btn_s;
    logic prog_btn_s;

    sbr_sync #(
        .W(5)
    ) u_sync (
        .clk(clk),
        .sys_rst(sys_rst),
        .async_in({panel_program_btn, panel_reset_btn, ext_control_in_c, ext_control_in_b, ext_control_in_a}),
        .sync_out(pins_s)
    );

    assign ext_s = pins_s[2:0];
    assign rst_btn_s = pins_s[3];
    assign prog_btn_s = pins_s[4];

    ////////////////////////////////////////////////////////////////////////////
    // register decode

    logic wr_bank;
    logic wr_reset;
    logic wr_stat;
    logic win_hit;

    assign wr_bank = reg_wr && reg_addr == `SBR_OFF_BANK;
    assign wr_reset = reg_wr && reg_addr == `SBR_OFF_RESET;
    assign wr_stat = reg_wr && reg_addr == `SBR_OFF_IRQ_STAT;
    assign win_hit = reg_addr[7:6] == `SBR_WIN_SEL;

    logic [`SBR_CMB_W-1:0] cmb_mask_q;
    logic [`SBR_PH_W-1:0] ph_mask_q;
    logic [`SBR_GND_W-1:0] gnd_mask_q;
    logic [3:0] hold_en_q;
    logic [`SBR_IRQ_W-1:0] irq_mask_q;
    logic [`SBR_EXT_W-1:0] ext_sw_q [3];

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            cmb_mask_q <= `SBR_RST_CMB;
            ph_mask_q <= `SBR_RST_PH;
            gnd_mask_q <= `SBR_RST_GND;
            hold_en_q <= `SBR_RST_HOLD;
            irq_mask_q <= '0;
        end else if (reg_wr) begin
            case (reg_addr)
                `SBR_OFF_AR_CMB: cmb_mask_q <= reg_wdata[`SBR_CMB_W-1:0];
                `SBR_OFF_AR_PH: ph_mask_q <= reg_wdata[`SBR_PH_W-1:0];
                `SBR_OFF_AR_GND: gnd_mask_q <= reg_wdata[`SBR_GND_W-1:0];
                `SBR_OFF_HOLD: hold_en_q <= reg_wdata[3:0];
                `SBR_OFF_IRQ_MASK: irq_mask_q <= reg_wdata[`SBR_IRQ_W-1:0];
                default: ;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // reclose initiation

    logic [`SBR_CMB_W-1:0] all_sig;

    assign all_sig = {ef_trip, ef_start, oc_trip, oc_start};

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            reclose_init_combined <= 1'b0;
            reclose_init_phase <= 1'b0;
            reclose_init_ground <= 1'b0;
        end else begin
            reclose_init_combined <= |(cmb_mask_q & all_sig);
            reclose_init_phase <= |(ph_mask_q & {oc_trip, oc_start});
            reclose_init_ground <= |(gnd_mask_q & {ef_trip, ef_start});
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // external control inputs: switchgroups, resets and bank choice

    logic [2:0] ext_bank_en;
    logic [2:0] ext_rise;
    logic [2:0] ext_ind;
    logic [2:0] ext_unl;
    logic [2:0] ext_erase;

    for (genvar k = 0; k < 3; k++) begin : g_ext
        always_ff @(posedge clk) begin
            if (sys_rst) begin
                ext_sw_q[k] <= `SBR_RST_EXT;
            end else if (reg_wr && reg_addr == `SBR_OFF_EXT_A + 8'(4 * k)) begin
                ext_sw_q[k] <= reg_wdata[`SBR_EXT_W-1:0];
            end
        end
        assign ext_bank_en[k] = ext_sw_q[k][`SBR_EXT_BANK_BIT];
        assign ext_rise[k] = ext_s[k] && !ext_prev_q[k];
        assign ext_ind[k] = ext_rise[k] && ext_sw_q[k][`SBR_EXT_IND_BIT];
        assign ext_unl[k] = ext_rise[k] && ext_sw_q[k][`SBR_EXT_UNL_BIT];
        assign ext_erase[k] = ext_rise[k] && ext_sw_q[k][`SBR_EXT_ERASE_BIT];
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            ext_prev_q <= '0;
        end else begin
            ext_prev_q <= ext_s;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // panel buttons: scope decided when all buttons are released

    sbr_btn_e btn_q;
    logic saw_rst_q;
    logic saw_prog_q;
    logic dark_q;
    logic btn_ind;
    logic btn_unl;
    logic btn_erase;
    logic btn_release;

    assign btn_release = btn_q == BTN_HELD && !rst_btn_s && !prog_btn_s;

    // acting on release lets a two-button press widen its scope instead of firing twice
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            btn_q <= BTN_IDLE;
            saw_rst_q <= 1'b0;
            saw_prog_q <= 1'b0;
            dark_q <= 1'b0;
        end else begin
            case (btn_q)
                BTN_IDLE: begin
                    if (rst_btn_s || prog_btn_s) begin
                        btn_q <= BTN_HELD;
                        saw_rst_q <= rst_btn_s;
                        saw_prog_q <= prog_btn_s;
                        dark_q <= display_dark;
                    end
                end
                BTN_HELD: begin
                    if (btn_release) begin
                        btn_q <= BTN_IDLE;
                    end else begin
                        saw_rst_q <= saw_rst_q | rst_btn_s;
                        saw_prog_q <= saw_prog_q | prog_btn_s;
                    end
                end
                default: btn_q <= BTN_IDLE;
            endcase
        end
    end

    assign btn_erase = btn_release && saw_rst_q && saw_prog_q;
    assign btn_unl = btn_release && saw_prog_q && !saw_rst_q && dark_q;
    assign btn_ind = btn_release && saw_rst_q && !saw_prog_q;

    ////////////////////////////////////////////////////////////////////////////
    // reset scopes

    logic bus_unl;
    logic bus_all;
    logic do_erase;
    logic do_unl;
    logic do_ind;

    assign bus_unl = wr_reset && reg_wdata[`SBR_RST_UNLATCH_BIT];
    assign bus_all = wr_reset && reg_wdata[`SBR_RST_ALL_BIT];
    // each wider scope includes the narrower ones
    assign do_erase = btn_erase || (|ext_erase) || bus_all;
    assign do_unl = do_erase || btn_unl || (|ext_unl) || bus_unl;
    assign do_ind = do_unl || btn_ind || (|ext_ind);

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            clear_indicators <= 1'b0;
            unlatch_outputs <= 1'b0;
            erase_registers <= 1'b0;
        end else begin
            clear_indicators <= do_ind;
            unlatch_outputs <= do_unl;
            erase_registers <= do_erase;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // self-holding trip outputs

    logic [3:0] trip_hold_q;

    // a cause still present keeps its output set through an unlatch
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            trip_hold_q <= '0;
            trip_output <= '0;
        end else begin
            trip_hold_q <= (do_unl ? 4'h0 : trip_hold_q) | (trip_route & hold_en_q);
            trip_output <= trip_route | (do_unl ? 4'h0 : trip_hold_q);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // setting bank selection

    logic soft_bank_q;
    logic ext_locked;
    logic ext_level;
    logic bank_d;

    assign ext_locked = |ext_bank_en;
    assign ext_level = |(ext_bank_en & ext_s);

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            soft_bank_q <= `SBR_BANK_MAIN;
        end else if (!ext_locked) begin
            if (wr_bank) begin
                soft_bank_q <= reg_wdata[`SBR_BANK_SEL_BIT];
            end else if (panel_bank_wr) begin
                soft_bank_q <= panel_bank_val ? `SBR_BANK_SECOND : `SBR_BANK_MAIN;
            end
        end
    end

    assign bank_d = ext_locked ? ext_level : soft_bank_q;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            active_bank <= `SBR_BANK_MAIN;
        end else begin
            active_bank <= bank_d;
        end
    end

    // lamp flashing
    logic [23:0] flash_cnt_q;
    logic flash_ph_q;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            flash_cnt_q <= '0;
            flash_ph_q <= 1'b0;
        end else if (flash_cnt_q == 24'(FLASH_HALF_CYC - 1)) begin
            flash_cnt_q <= '0;
            flash_ph_q <= !flash_ph_q;
        end else begin
            flash_cnt_q <= flash_cnt_q + 24'h000001;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            setting_lamp_on <= 1'b1;
        end else begin
            setting_lamp_on <= active_bank == `SBR_BANK_SECOND ? flash_ph_q : 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // setting store

    sbr_set_t bus_set_rdata;
    sbr_set_t pnl_rdata;

    sbr_bank_store u_store (
        .clk(clk),
        .sys_rst(sys_rst),
        .active_bank(active_bank),
        .bus_bank(reg_addr[5]),
        .bus_idx(reg_addr[4:2]),
        .bus_wr(reg_wr && win_hit),
        .bus_wdata(reg_wdata[15:0]),
        .bus_rdata(bus_set_rdata),
        .pnl_idx(panel_set_idx),
        .pnl_wr(panel_set_wr),
        .pnl_wdata(panel_set_wdata),
        .pnl_rdata(pnl_rdata)
    );

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            panel_set_rdata <= `SBR_RST_SET;
        end else begin
            panel_set_rdata <= pnl_rdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // interrupt status

    logic [`SBR_IRQ_W-1:0] irq_stat_q;
    logic [`SBR_IRQ_W-1:0] irq_evt;

    assign irq_evt = {do_erase, do_unl, do_ind, bank_d != active_bank};

    // a new event in the clearing cycle survives the write-one-to-clear
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            irq_stat_q <= '0;
        end else begin
            irq_stat_q <= (irq_stat_q & ~(wr_stat ? reg_wdata[`SBR_IRQ_W-1:0] : 4'h0)) | irq_evt;
        end
    end

    assign irq = |(irq_stat_q & irq_mask_q);

    ////////////////////////////////////////////////////////////////////////////
    // read data, valid only in the cycle after the read strobe

    sbr_word_t rd_d;

    always_comb begin
        rd_d = '0;
        if (win_hit) begin
            rd_d = {16'h0000, bus_set_rdata};
        end else begin
            case (reg_addr)
                `SBR_OFF_BANK: rd_d = {29'h00000000, soft_bank_q, ext_locked, active_bank};
                `SBR_OFF_AR_CMB: rd_d = {22'h000000, cmb_mask_q};
                `SBR_OFF_AR_PH: rd_d = {26'h0000000, ph_mask_q};
                `SBR_OFF_AR_GND: rd_d = {28'h0000000, gnd_mask_q};
                `SBR_OFF_EXT_A: rd_d = {23'h000000, ext_sw_q[0]};
                `SBR_OFF_EXT_B: rd_d = {23'h000000, ext_sw_q[1]};
                `SBR_OFF_EXT_C: rd_d = {23'h000000, ext_sw_q[2]};
                `SBR_OFF_HOLD: rd_d = {28'h0000000, hold_en_q};
                `SBR_OFF_IRQ_STAT: rd_d = {28'h0000000, irq_stat_q};
                `SBR_OFF_IRQ_MASK: rd_d = {28'h0000000, irq_mask_q};
                default: rd_d = '0;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            reg_rdata <= '0;
        end else begin
            reg_rdata <= reg_rd ? rd_d : 32'h00000000;
        end
    end
endmodule // sbr_ctrl

/* rtl/sbr_pkg.sv */
/*
 * Types of the setting bank and reset logic.
 * Assumes sbr_consts.svh carries the numeric constants.
 */
package sbr_pkg;
    typedef logic [31:0] sbr_word_t;
    typedef logic [7:0] sbr_addr_t;
    typedef logic [15:0] sbr_set_t;
    typedef logic [2:0] sbr_idx_t;
    typedef enum logic {BTN_IDLE, BTN_HELD} sbr_btn_e;
endpackage

/* rtl/sbr_sync.sv */
/*
 * Two-flop synchroniser for a group of pin inputs.
 * Assumes the inputs are asynchronous to clk.
 */
module sbr_sync #(
    parameter int W = 5
) (
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // pins and synchronised levels
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);
    logic [W-1:0] meta_q;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            meta_q <= '0;
            sync_out <= '0;
        end else begin
            meta_q <= async_in;
            sync_out <= meta_q;
        end
    end
endmodule // sbr_sync
